// >>> hw/nel_log_backup.sv
/*
  Event log and polling-node succession logic of one network node.
  Assumes one 250 MHz clock, synchronous inputs, single-cycle event pulses,
  and a message layer that decodes log commands into CMD_VALID_IN/CODE.
*/
// What this block does
// [R1] Node loss logs four removed-node bitmap entries
// [R2] Bitmaps logged together with node-loss entry
// [R3] Low tx-failure codes logged only if discarded
// [R4] Cycle error logs set and minimum times
// [R5] Data link inactive logged, kept nonvolatile
// [R6] Packet discard logged, not kept nonvolatile
// [R7] Unit error logged, kept nonvolatile
// [R8] Log-read command returns logged entries
// [R9] Log-clear command empties the log
// [R10] Address one polls at network start
// [R11] Next smallest healthy address takes polling over
// [R12] No communications during reconstruction
// [R13] Data link held during reconstruction, then resumed
// [R14] Reconstruction time from new and highest address
// [R15] Optical node bypassed on fault with backup
// [R16] Polling change logs old and new address
// [R17] Entries are code plus two bytes, ordered
`timescale 1ns/1ns
`include "nel_cfg.svh"
module nel_log_backup #(
  parameter int DEPTH     = 64,
  parameter int MS_CYCLES = `NEL_CLK_HZ / `NEL_MS_PER_S
) (
  // Clock and reset
  input  wire logic                    CLK_IN,
  input  wire logic                    SRST_IN,
  // Transmission failure event
  input  wire logic                    EV_TX_IN,
  input  wire logic [15:0]             TX_CODE_IN,
  input  wire logic [15:0]             TX_DETAIL_IN,
  input  wire logic                    TX_DISCARD_IN,
  input  wire logic                    TX_KEEP_IN,
  // Participating nodes decreased
  input  wire logic                    EV_LOSS_IN,
  input  wire logic                    LOCAL_IN_NET_IN,
  input  wire logic [61:0]             LOST_MAP_IN,
  // Other events
  input  wire logic                    EV_CYC_ERR_IN,
  input  wire logic [7:0]              CYC_SET_MS_IN,
  input  wire logic [7:0]              CYC_MIN_MS_IN,
  input  wire logic                    EV_DL_INACT_IN,
  input  wire logic                    EV_PKT_DROP_IN,
  input  wire logic                    EV_UNIT_ERR_IN,
  // Log commands and responses
  input  wire logic                    CMD_VALID_IN,
  input  wire logic [15:0]             CMD_CODE_IN,
  output      logic                    RSP_VALID_OUT,
  output      nel_pkg::nel_entry_s     RSP_ENTRY_OUT,
  output      logic                    RSP_END_OUT,
  output      logic                    NV_WR_OUT,
  output      nel_pkg::nel_entry_s     NV_ENTRY_OUT,
  // Polling role
  input  wire logic [5:0]              MY_ADDR_IN,
  input  wire logic [5:0]              MAX_ADDR_IN,
  input  wire logic                    NET_START_IN,
  input  wire logic                    POLL_FAIL_IN,
  input  wire logic [61:0]             HEALTHY_MAP_IN,
  output      logic [5:0]              POLL_ADDR_OUT,
  output      logic                    IS_POLLER_OUT,
  output      logic                    RECON_OUT,
  output      logic                    COMM_EN_OUT,
  output      logic                    DL_HOLD_OUT,
  // Optical bypass
  input  wire logic                    OPTICAL_IN,
  input  wire logic                    BACKUP_PWR_IN,
  input  wire logic                    LOCAL_FAULT_IN,
  input  wire logic                    LOCAL_PWR_LOSS_IN,
  output      logic                    BYPASS_OUT
);
  localparam int AW = $clog2(DEPTH);
  localparam int RECON_MS_W = 12;
  localparam int MS_W = $clog2(MS_CYCLES + 1);
  // Lowest set bit of a node map as an address, zero when none
  function automatic logic [5:0] lowest_node(input logic [61:0] m);
    logic [5:0] a;
    a = `NEL_RST_ADDR;
    for (int i = `NEL_NODE_COUNT - 1; i >= 0; i--) begin
      if (m[i]) begin
        a = 6'(i + 1);
      end
    end
    return a;
  endfunction
  // Count of removed nodes
  function automatic logic [7:0] ones(input logic [61:0] m);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < `NEL_NODE_COUNT; i++) begin
      n = n + {7'h00, m[i]};
    end
    return n;
  endfunction

  nel_pkg::nel_entry_s mem [DEPTH];       // Log storage, ring
  logic [AW-1:0]       wr_ptr_r;          // Next slot to fill
  logic [AW:0]         count_r;           // Entries held
  logic [6:0]          pend_r;            // Pending event sources
  nel_pkg::nel_entry_s tx_p_r;            // Captured tx entry
  logic [7:0]          cyc_set_r;         // Captured cycle times
  logic [7:0]          cyc_min_r;
  logic                loss_in_r;         // Captured loss variant
  logic [61:0]         loss_p_r;          // Captured removed map
  logic [63:0]         loss_w_r;          // Map being written out
  logic [2:0]          loss_step_r;       // Bitmap entry sequencer
  logic [5:0]          pc_old_r;          // Polling change addresses
  logic [5:0]          pc_new_r;
  logic                wr_en;
  nel_pkg::nel_entry_s wr_d;
  logic [6:0]          grant;
  logic                tx_ok;
  logic                cmd_ok;
  logic                rd_go;
  logic                clr_go;
  nel_pkg::nel_rd_e    rd_st_r;
  logic [AW-1:0]       rd_ptr_r;
  logic [AW:0]         rd_left_r;
  nel_pkg::nel_pl_e    pl_st_r;
  logic [RECON_MS_W-1:0] ms_left_r;       // Whole ms still to wait
  logic [MS_W-1:0]     ms_cnt_r;          // Cycles within one ms
  logic [5:0]          cand;              // Successor candidate
  logic                pc_ev;             // Polling role moved

  // Only discarded frames count for the low tx-failure range
  assign tx_ok = EV_TX_IN && (TX_DISCARD_IN ||
                 TX_CODE_IN < `NEL_CODE_TX_LO ||
                 TX_CODE_IN > `NEL_CODE_TX_HI);         // see [R3]
  // Commands are not accepted while the network is rebuilt
  assign cmd_ok = CMD_VALID_IN && pl_st_r == nel_pkg::NEL_PL_RUN; // see [R12]
  assign rd_go  = cmd_ok && CMD_CODE_IN == `NEL_CMD_LOG_READ;
  assign clr_go = cmd_ok && CMD_CODE_IN == `NEL_CMD_LOG_CLEAR;
  assign cand   = lowest_node(HEALTHY_MAP_IN &
                  ~(62'h1 << (POLL_ADDR_OUT - 6'h01)));  // see [R11]
  assign pc_ev  = POLL_FAIL_IN && pl_st_r == nel_pkg::NEL_PL_RUN &&
                  cand != `NEL_RST_ADDR;

  // Pending flags; a new event in the consuming cycle stays pending
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      pend_r <= 7'h00;
    end else begin
      pend_r <= (pend_r & ~grant) |
                {pc_ev, EV_UNIT_ERR_IN, EV_PKT_DROP_IN, EV_DL_INACT_IN,
                 EV_CYC_ERR_IN, EV_LOSS_IN, tx_ok};
    end
  end

  // Event detail capture
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      tx_p_r    <= '0;
      cyc_set_r <= 8'h00;
      cyc_min_r <= 8'h00;
      loss_in_r <= 1'b0;
      loss_p_r  <= 62'h0;
      pc_old_r  <= `NEL_RST_ADDR;
      pc_new_r  <= `NEL_RST_ADDR;
    end else begin
      if (tx_ok) begin
        tx_p_r <= '{TX_CODE_IN, TX_DETAIL_IN[15:8], TX_DETAIL_IN[7:0],
                    TX_KEEP_IN};
      end
      if (EV_CYC_ERR_IN) begin
        cyc_set_r <= CYC_SET_MS_IN;
        cyc_min_r <= CYC_MIN_MS_IN;
      end
      if (EV_LOSS_IN) begin
        loss_in_r <= LOCAL_IN_NET_IN;
        loss_p_r  <= LOST_MAP_IN;
      end
      if (pc_ev) begin
        pc_old_r <= POLL_ADDR_OUT;
        pc_new_r <= cand;
      end
    end
  end

  // Pick one entry per cycle; bitmap steps lock out everything else
  always_comb begin
    grant = 7'h00;
    wr_en = 1'b0;
    wr_d  = '0;
    if (loss_step_r != 3'h0) begin
      wr_en = 1'b1;                                     // see [R2]
      wr_d  = '{`NEL_CODE_MAP_0 + {14'h0, 2'(loss_step_r - 3'h1)},
                loss_w_r[15:8], loss_w_r[7:0], 1'b1};   // see [R1]
    end else begin
      for (int i = 6; i >= 0; i--) begin
        if (pend_r[i]) begin
          grant = 7'h01 << i;
        end
      end
      wr_en = pend_r != 7'h00;
      unique case (1'b1)
        grant[0]: wr_d = tx_p_r;
        grant[1]: wr_d = '{loss_in_r ? `NEL_CODE_LOSS_IN : `NEL_CODE_LOSS_OUT,
                           {2'h0, MAX_ADDR_IN}, ones(loss_p_r), 1'b0};
        grant[2]: wr_d = '{`NEL_CODE_CYC_ERR, cyc_set_r, cyc_min_r,
                           1'b1};                        // see [R4]
        grant[3]: wr_d = '{`NEL_CODE_DL_INACT, 8'h00, 8'h00, 1'b1}; // see [R5]
        grant[4]: wr_d = '{`NEL_CODE_PKT_DROP, 8'h00, 8'h00, 1'b0}; // see [R6]
        grant[5]: wr_d = '{`NEL_CODE_UNIT_ERR, 8'h00, 8'h00, 1'b1}; // see [R7]
        grant[6]: wr_d = '{`NEL_CODE_POLL_CHG, {2'h0, pc_old_r},
                           {2'h0, pc_new_r}, 1'b0};      // see [R16]
        default:  wr_d = '0;
      endcase
    end
  end

  // Bitmap sequencer: four slices after the node-loss entry
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      loss_step_r <= 3'h0;
      loss_w_r    <= 64'h0;
    end else if (grant[1]) begin
      loss_step_r <= 3'h1;
      loss_w_r    <= {2'h0, loss_p_r};                   // see [R1]
    end else if (loss_step_r != 3'h0) begin
      loss_step_r <= (loss_step_r == 3'h4) ? 3'h0 : loss_step_r + 3'h1;
      loss_w_r    <= loss_w_r >> `NEL_MAP_SLICE;
    end
  end

  // Log storage in order of occurrence, oldest lost on overflow
  always_ff @(posedge CLK_IN) begin
    if (wr_en) begin
      mem[wr_ptr_r] <= wr_d;                             // see [R17]
    end
  end

  // Fill pointer and count; a write in the clearing cycle survives
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      wr_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + AW'(wr_en);
      if (clr_go) begin
        count_r <= (AW+1)'(wr_en);                       // see [R9]
      end else if (wr_en && count_r != (AW+1)'(DEPTH)) begin
        count_r <= count_r + (AW+1)'(1);
      end
    end
  end

  // Copy of entries that must survive power loss
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      NV_WR_OUT    <= 1'b0;
      NV_ENTRY_OUT <= '0;
    end else begin
      NV_WR_OUT    <= wr_en && wr_d.keep;                // see [R6]
      NV_ENTRY_OUT <= wr_d;
    end
  end

  // Log read streams oldest first; a clear aborts it
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      rd_st_r       <= nel_pkg::NEL_RD_IDLE;
      rd_ptr_r      <= '0;
      rd_left_r     <= '0;
      RSP_VALID_OUT <= 1'b0;
      RSP_ENTRY_OUT <= '0;
      RSP_END_OUT   <= 1'b0;
    end else begin
      RSP_VALID_OUT <= 1'b0;
      RSP_END_OUT   <= 1'b0;
      unique case (rd_st_r)
        nel_pkg::NEL_RD_IDLE: begin
          if (rd_go) begin
            rd_st_r   <= nel_pkg::NEL_RD_RUN;            // see [R8]
            rd_ptr_r  <= wr_ptr_r - AW'(count_r);
            rd_left_r <= count_r;
          end
        end
        nel_pkg::NEL_RD_RUN: begin
          if (rd_left_r == '0 || clr_go) begin
            rd_st_r     <= nel_pkg::NEL_RD_IDLE;
            RSP_END_OUT <= 1'b1;
          end else begin
            RSP_VALID_OUT <= 1'b1;
            RSP_ENTRY_OUT <= mem[rd_ptr_r];
            rd_ptr_r      <= rd_ptr_r + AW'(1);
            rd_left_r     <= rd_left_r - (AW+1)'(1);
          end
        end
      endcase
    end
  end

  // Polling role and reconstruction timer
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      pl_st_r       <= nel_pkg::NEL_PL_RUN;
      POLL_ADDR_OUT <= `NEL_RST_ADDR;
      ms_left_r     <= '0;
      ms_cnt_r      <= '0;
    end else if (NET_START_IN) begin
      pl_st_r       <= nel_pkg::NEL_PL_RUN;
      POLL_ADDR_OUT <= `NEL_FIRST_POLLER;                // see [R10]
    end else if (pc_ev) begin
      pl_st_r       <= nel_pkg::NEL_PL_RECON;
      POLL_ADDR_OUT <= cand;                             // see [R11]
      ms_left_r     <= RECON_MS_W'(({6'h0, cand} + 12'h1) *
                       12'(`NEL_RECON_STEP_MS) +
                       {6'h0, MAX_ADDR_IN} *
                       12'(`NEL_RECON_NODE_MS));          // see [R14]
      ms_cnt_r      <= '0;
    end else if (pl_st_r == nel_pkg::NEL_PL_RECON) begin
      if (ms_cnt_r == MS_W'(MS_CYCLES - 1)) begin
        ms_cnt_r <= '0;
        if (ms_left_r <= RECON_MS_W'(1)) begin
          pl_st_r <= nel_pkg::NEL_PL_RUN;                // see [R13]
        end
        ms_left_r <= ms_left_r - RECON_MS_W'(1);
      end else begin
        ms_cnt_r <= ms_cnt_r + MS_W'(1);
      end
    end
  end

  // Status flags; the data link holds its areas while rebuilding
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      RECON_OUT     <= 1'b0;
      COMM_EN_OUT   <= 1'b0;
      DL_HOLD_OUT   <= 1'b0;
      IS_POLLER_OUT <= 1'b0;
      BYPASS_OUT    <= 1'b0;
    end else begin
      RECON_OUT     <= pl_st_r == nel_pkg::NEL_PL_RECON;
      COMM_EN_OUT   <= pl_st_r == nel_pkg::NEL_PL_RUN;   // see [R12]
      DL_HOLD_OUT   <= pl_st_r == nel_pkg::NEL_PL_RECON; // see [R13]
      IS_POLLER_OUT <= POLL_ADDR_OUT == MY_ADDR_IN &&
                       POLL_ADDR_OUT != `NEL_RST_ADDR;
      BYPASS_OUT    <= OPTICAL_IN && BACKUP_PWR_IN &&
                       (LOCAL_FAULT_IN || LOCAL_PWR_LOSS_IN); // see [R15]
    end
  end

  a_loss_bitmaps: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // see [R2]
    grant[1] |=> wr_en && wr_d.code == `NEL_CODE_MAP_0 ##3
                 wr_d.code == `NEL_CODE_MAP_3) else $error("bitmap order");
  a_last_slice: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // see [R1]
    wr_en && wr_d.code == `NEL_CODE_MAP_3 |-> wr_d.d1[7:6] == 2'h0)
    else $error("node 63 or 64 logged");
  a_tx_filter: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // see [R3]
    EV_TX_IN && !TX_DISCARD_IN && TX_CODE_IN == `NEL_CODE_TX_LO &&
    !pend_r[0] |=> !pend_r[0]) else $error("unsent frame logged");
  a_nv_policy: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // see [R5]
    wr_en && (wr_d.code == `NEL_CODE_DL_INACT ||
    wr_d.code == `NEL_CODE_UNIT_ERR) |=> NV_WR_OUT) else $error("nv miss");
  a_pkt_volatile: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // see [R6]
    wr_en && wr_d.code == `NEL_CODE_PKT_DROP |=> !NV_WR_OUT)
    else $error("discard kept");
  a_clear_empties: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // see [R9]
    clr_go && !wr_en |=> count_r == '0) else $error("log not cleared");
  a_empty_read: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // see [R8]
    rd_go && rd_st_r == nel_pkg::NEL_RD_IDLE && count_r == '0 |=>
    !RSP_VALID_OUT ##1 RSP_END_OUT) else $error("empty read");
  a_start_poller: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // see [R10]
    NET_START_IN |=> POLL_ADDR_OUT == `NEL_FIRST_POLLER)
    else $error("wrong first poller");
  a_recon_quiet: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // see [R12]
    pc_ev && !NET_START_IN |=> ##1 !COMM_EN_OUT && DL_HOLD_OUT)
    else $error("comms during rebuild");
  a_poll_log: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // see [R16]
    pc_ev |=> pend_r[6] && pc_new_r == POLL_ADDR_OUT)
    else $error("change not logged");
  a_bypass_set: assert property (@(posedge CLK_IN) disable iff (SRST_IN) // see [R15]
    OPTICAL_IN && BACKUP_PWR_IN && LOCAL_FAULT_IN |=> BYPASS_OUT)
    else $error("no bypass");
endmodule

// >>> hw/nel_cfg.svh
/*
  Constants for the event log and polling-node succession block: error codes,
  message command codes, reset values and reconstruction timing.
  Assumes inclusion by bare name from the design file.
*/
`ifndef NEL_CFG_SVH
`define NEL_CFG_SVH
// Error codes written into the log
`define NEL_CODE_TX_LO    16'h0101
`define NEL_CODE_TX_HI    16'h0116
`define NEL_CODE_LOSS_IN  16'h0206
`define NEL_CODE_LOSS_OUT 16'h0207
`define NEL_CODE_POLL_CHG 16'h0208
`define NEL_CODE_DL_INACT 16'h021c
`define NEL_CODE_CYC_ERR  16'h021d
`define NEL_CODE_MAP_0    16'h0220
`define NEL_CODE_MAP_3    16'h0223
`define NEL_CODE_PKT_DROP 16'h0300
`define NEL_CODE_UNIT_ERR 16'h0601
// Message service command codes
`define NEL_CMD_LOG_READ  16'h2102
`define NEL_CMD_LOG_CLEAR 16'h2103
// Node addressing
`define NEL_FIRST_POLLER  6'h01
`define NEL_NODE_COUNT    62
`define NEL_MAP_SLICE     16
`define NEL_RST_ADDR      6'h00
// Reconstruction timing
`define NEL_CLK_HZ        250000000
`define NEL_MS_PER_S      1000
`define NEL_RECON_STEP_MS 20
`define NEL_RECON_NODE_MS 1
`endif

// >>> hw/nel_pkg.sv
/*
  Types shared by the event log and polling-node succession block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package nel_pkg;
  // One log entry: code, two detail bytes, nonvolatile-copy flag
  typedef struct packed {
    logic [15:0] code;
    logic [7:0]  d1;
    logic [7:0]  d2;
    logic        keep;
  } nel_entry_s;
  // Log read sequencer
  typedef enum logic [0:0] {
    NEL_RD_IDLE = 1'b0,
    NEL_RD_RUN  = 1'b1
  } nel_rd_e;
  // Polling role state
  typedef enum logic [0:0] {
    NEL_PL_RUN   = 1'b0,
    NEL_PL_RECON = 1'b1
  } nel_pl_e;
endpackage

// >>> test/nel_peer.sv
/*
  Model of the other network nodes: issues log commands, gathers replies
  and reports which nodes are healthy.
  Assumes the node answers on registered response ports, one cycle each.
*/
`timescale 1ns/1ns
`include "nel_cfg.svh"
module nel_peer (
  // Clock
  input  wire logic                CLK_IN,
  // Replies from the node
  input  wire logic                RSP_VALID_IN,
  input  wire nel_pkg::nel_entry_s RSP_ENTRY_IN,
  input  wire logic                RSP_END_IN,
  // Requests to the node
  output      logic                CMD_VALID_OUT,
  output      logic [15:0]         CMD_CODE_OUT,
  output      logic [61:0]         HEALTHY_MAP_OUT
);
  nel_pkg::nel_entry_s got_q[$];  // Entries returned by the last read
  logic                got_end;   // High once the last read finished

  // Idle bus, every node healthy
  initial begin
    CMD_VALID_OUT = 1'b0;
    CMD_CODE_OUT = 16'h0000;
    HEALTHY_MAP_OUT = '1;
    got_end = 1'b0;
  end

  // One command pulse, launched and dropped on rising edges
  task automatic send(input logic [15:0] code);
    @(posedge CLK_IN);
    CMD_VALID_OUT <= 1'b1;
    CMD_CODE_OUT <= code;
    @(posedge CLK_IN);
    CMD_VALID_OUT <= 1'b0;
  endtask

  // Read request; a silent node is waited out, never hung on
  task automatic read_log();
    got_q.delete();
    got_end = 1'b0;
    send(`NEL_CMD_LOG_READ);
    for (int i = 0; i < 200 && got_end !== 1'b1; i++) begin
      @(negedge CLK_IN);
      if (RSP_VALID_IN === 1'b1) begin
        got_q.push_back(RSP_ENTRY_IN);
      end
      if (RSP_END_IN === 1'b1) begin
        got_end = 1'b1;
      end
    end
    // Realign so callers drive on a rising edge again
    @(posedge CLK_IN);
  endtask
endmodule

// >>> test/tb_nel_log_backup.sv
/*
  Self-checking bench for the event log and polling succession block.
  Assumes the peer model in nel_peer.sv and the shared constants header.
*/
`timescale 1ns/1ns
`include "nel_cfg.svh"
module tb_nel_log_backup;
  localparam int MS = 4;  // Short millisecond keeps the rebuild brief
  localparam int RECON = ((3 + 1) * `NEL_RECON_STEP_MS
                          + 62 * `NEL_RECON_NODE_MS) * MS;
  logic        clk, srst;                         // Clock and reset
  logic        ev_tx, tx_dis, tx_keep, ev_loss;   // Event strobes
  logic        loc_in, ev_cyc, ev_dl, ev_pkt, ev_unit;
  logic        net_start, poll_fail, opt, bkp, flt, pwl;
  logic [15:0] tx_code, tx_det, cmd_code;         // Codes and details
  logic [61:0] lost_map, healthy;                 // Node bitmaps
  logic [7:0]  cyc_set, cyc_min;                  // Cycle times in ms
  logic [5:0]  my_addr, max_addr, poll_addr;      // Node addresses
  logic        cmd_v, rsp_v, rsp_end, nv_wr;      // Message side
  logic        is_poll, recon, comm_en, dl_hold, bypass;
  nel_pkg::nel_entry_s rsp_e, nv_e;               // Entry buses
  nel_pkg::nel_entry_s exp_q[$];                  // Expected log
  nel_pkg::nel_entry_s nv_last;                   // Last nonvolatile copy
  int          fail_count, num_checks, nv_cnt, recon_cnt;

  nel_log_backup #(.MS_CYCLES(MS)) nel_log_backup_i (
    .CLK_IN(clk), .SRST_IN(srst),
    .EV_TX_IN(ev_tx), .TX_CODE_IN(tx_code), .TX_DETAIL_IN(tx_det),
    .TX_DISCARD_IN(tx_dis), .TX_KEEP_IN(tx_keep),
    .EV_LOSS_IN(ev_loss), .LOCAL_IN_NET_IN(loc_in),
    .LOST_MAP_IN(lost_map), .EV_CYC_ERR_IN(ev_cyc),
    .CYC_SET_MS_IN(cyc_set), .CYC_MIN_MS_IN(cyc_min),
    .EV_DL_INACT_IN(ev_dl), .EV_PKT_DROP_IN(ev_pkt),
    .EV_UNIT_ERR_IN(ev_unit), .CMD_VALID_IN(cmd_v),
    .CMD_CODE_IN(cmd_code), .RSP_VALID_OUT(rsp_v),
    .RSP_ENTRY_OUT(rsp_e), .RSP_END_OUT(rsp_end), .NV_WR_OUT(nv_wr),
    .NV_ENTRY_OUT(nv_e), .MY_ADDR_IN(my_addr), .MAX_ADDR_IN(max_addr),
    .NET_START_IN(net_start), .POLL_FAIL_IN(poll_fail),
    .HEALTHY_MAP_IN(healthy), .POLL_ADDR_OUT(poll_addr),
    .IS_POLLER_OUT(is_poll), .RECON_OUT(recon), .COMM_EN_OUT(comm_en),
    .DL_HOLD_OUT(dl_hold), .OPTICAL_IN(opt), .BACKUP_PWR_IN(bkp),
    .LOCAL_FAULT_IN(flt), .LOCAL_PWR_LOSS_IN(pwl), .BYPASS_OUT(bypass));

  nel_peer nel_peer_i (
    .CLK_IN(clk), .RSP_VALID_IN(rsp_v), .RSP_ENTRY_IN(rsp_e),
    .RSP_END_IN(rsp_end), .CMD_VALID_OUT(cmd_v),
    .CMD_CODE_OUT(cmd_code), .HEALTHY_MAP_OUT(healthy));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Nonvolatile copies and rebuild cycles are counted as they happen
  always @(posedge clk) begin
    if (nv_wr === 1'b1) begin
      nv_cnt++;
      nv_last = nv_e;
    end
    if (recon === 1'b1) recon_cnt++;
  end

  // Case equality so an unknown never passes
  task automatic check(input logic [40:0] seen, exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  function automatic nel_pkg::nel_entry_s mk(input logic [15:0] c,
      input logic [7:0] a, b, input logic k);
    return {c, a, b, k};
  endfunction

  // Pulse one event for one cycle, then let its entries land
  task automatic ev(input int k);
    @(posedge clk);
    case (k)
      0: ev_tx <= 1'b1;
      1: ev_loss <= 1'b1;
      2: ev_cyc <= 1'b1;
      3: ev_dl <= 1'b1;
      4: ev_pkt <= 1'b1;
      5: ev_unit <= 1'b1;
      6: net_start <= 1'b1;
      default: poll_fail <= 1'b1;
    endcase
    @(posedge clk);
    {ev_tx, ev_loss, ev_cyc, ev_dl, ev_pkt, ev_unit} <= '0;
    {net_start, poll_fail} <= '0;
    repeat (8) @(posedge clk);
  endtask

  task automatic clr();
    nel_peer_i.send(`NEL_CMD_LOG_CLEAR);
    repeat (3) @(posedge clk);
    exp_q.delete();
  endtask

  // Whole log read back and compared in order
  task automatic cmp_log();
    nel_peer_i.read_log();
    check(nel_peer_i.got_end, 1'b1, "read end");
    check(nel_peer_i.got_q.size(), exp_q.size(), "log size");
    foreach (exp_q[i])
      if (i < nel_peer_i.got_q.size())
        check(nel_peer_i.got_q[i], exp_q[i], "entry");
  endtask

  task automatic t_start();
    // The first edge that sees reset low is one after the release edge
    @(posedge clk);
    @(negedge clk);
    check(poll_addr, 6'h00, "poller before start");
    check(comm_en, 1'b1, "comm after reset");
    @(posedge clk);
    ev(6);
    @(negedge clk);
    check(poll_addr, `NEL_FIRST_POLLER, "first poller");
    check(is_poll, 1'b0, "not own address");
    @(posedge clk);
  endtask

  task automatic t_misc();
    int nv0;
    clr();
    nv0 = nv_cnt;
    cyc_set <= 8'h0a;
    cyc_min <= 8'h03;
    for (int k = 2; k < 6; k++) ev(k);
    exp_q.push_back(mk(`NEL_CODE_CYC_ERR, 8'h0a, 8'h03, 1'b1));
    exp_q.push_back(mk(`NEL_CODE_DL_INACT, 8'h00, 8'h00, 1'b1));
    exp_q.push_back(mk(`NEL_CODE_PKT_DROP, 8'h00, 8'h00, 1'b0));
    exp_q.push_back(mk(`NEL_CODE_UNIT_ERR, 8'h00, 8'h00, 1'b1));
    cmp_log();
    check(nv_cnt - nv0, 3, "nv copies");
    check(nv_last, mk(`NEL_CODE_UNIT_ERR, 8'h00, 8'h00, 1'b1),
          "nv entry");
  endtask

  // Undiscarded low codes vanish; discarded ones and others stay
  task automatic t_tx();
    clr();
    tx_code <= `NEL_CODE_TX_LO;
    tx_keep <= 1'b1;
    ev(0);
    tx_code <= `NEL_CODE_TX_HI;
    ev(0);
    tx_dis <= 1'b1;
    tx_det <= 16'h1234;
    ev(0);
    tx_code <= 16'h0117;
    tx_dis <= 1'b0;
    tx_keep <= 1'b0;
    tx_det <= 16'hbeef;
    ev(0);
    exp_q.push_back(mk(`NEL_CODE_TX_HI, 8'h12, 8'h34, 1'b1));
    exp_q.push_back(mk(16'h0117, 8'hbe, 8'hef, 1'b0));
    cmp_log();
    check(nel_peer_i.got_q.size(), 2, "tx entries");
  endtask

  // Nodes 16 and 62 lost, once still in and once out of the network
  task automatic t_loss();
    int nv0;
    clr();
    nv0 = nv_cnt;
    lost_map <= 62'h2000000000008000;
    for (int v = 1; v >= 0; v--) begin
      loc_in <= v[0];
      ev(1);
      exp_q.push_back(mk(v ? `NEL_CODE_LOSS_IN : `NEL_CODE_LOSS_OUT,
                         8'h3e, 8'h02, 1'b0));
      exp_q.push_back(mk(`NEL_CODE_MAP_0, 8'h80, 8'h00, 1'b1));
      exp_q.push_back(mk(`NEL_CODE_MAP_0 + 16'h1, 8'h00, 8'h00, 1'b1));
      exp_q.push_back(mk(`NEL_CODE_MAP_0 + 16'h2, 8'h00, 8'h00, 1'b1));
      exp_q.push_back(mk(`NEL_CODE_MAP_3, 8'h20, 8'h00, 1'b1));
    end
    cmp_log();
    check(nv_cnt - nv0, 8, "bitmap nv copies");
  endtask

  task automatic t_clear();
    nel_peer_i.read_log();
    clr();
    nel_peer_i.read_log();
    check(nel_peer_i.got_q.size(), 0, "cleared log");
  endtask

  // Poller 1 fails; node 2 is down, so node 3 takes over
  task automatic t_recon();
    clr();
    nel_peer_i.HEALTHY_MAP_OUT <= 62'hd;
    recon_cnt = 0;
    ev(7);
    @(negedge clk);
    check(poll_addr, 6'h03, "new poller");
    check(comm_en, 1'b0, "comm in rebuild");
    check(dl_hold, 1'b1, "hold in rebuild");
    @(posedge clk);
    nel_peer_i.read_log();
    check(nel_peer_i.got_end, 1'b0, "read in rebuild");
    for (int i = 0; i < 2000 && recon !== 1'b0; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(recon_cnt >= RECON && recon_cnt <= RECON + 1, 1'b1,
          "rebuild length");
    check(comm_en, 1'b1, "comm resumed");
    check(dl_hold, 1'b0, "hold released");
    check(is_poll, 1'b1, "own poll role");
    @(posedge clk);
    exp_q.push_back(mk(`NEL_CODE_POLL_CHG, 8'h01, 8'h03, 1'b0));
    cmp_log();
  endtask

  task automatic t_bypass();
    for (int i = 0; i < 16; i++) begin
      {opt, bkp, flt, pwl} <= i[3:0];
      repeat (2) @(posedge clk);
      @(negedge clk);
      check(bypass, i[3] & i[2] & (i[1] | i[0]), "bypass");
      @(posedge clk);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // A hang counts as a mismatch
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end

  initial begin
    {ev_tx, tx_dis, tx_keep, ev_loss, ev_cyc, ev_dl, ev_pkt} = '0;
    {ev_unit, net_start, poll_fail, opt, bkp, flt, pwl} = '0;
    loc_in = 1'b1;
    tx_code = 16'h0000;
    tx_det = 16'h0000;
    lost_map = '0;
    cyc_set = 8'h00;
    cyc_min = 8'h00;
    my_addr = 6'h03;
    max_addr = 6'h3e;
    srst = 1'b1;
    fail_count = 0;
    num_checks = 0;
    nv_cnt = 0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_start();
    t_misc();
    t_tx();
    t_loss();
    t_clear();
    t_recon();
    t_bypass();
    print_verdict();
  end
endmodule
